// [msplc_pkg.sv]
// Purpose: Shared constants and types for the serial port line control block.
// Assumes: 100 MHz system clock, one aligned 32-bit word per register.
// Notes:   Register offsets are byte addresses on the plain register port.
package msplc_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_BAUD   = 8'h04;
    localparam logic [7:0] A_MSDIV  = 8'h08;
    localparam logic [7:0] A_RTSON  = 8'h0C;
    localparam logic [7:0] A_RTSOFF = 8'h10;
    localparam logic [7:0] A_EOMDLY = 8'h14;
    localparam logic [7:0] A_FSTART = 8'h18;
    localparam logic [7:0] A_FBASE  = 8'h1C;
    localparam logic [7:0] A_TXDATA = 8'h20;
    localparam logic [7:0] A_RXDATA = 8'h24;
    localparam logic [7:0] A_STATUS = 8'h28;
    localparam logic [7:0] A_MAP    = 8'h2C;
    localparam logic [7:0] A_CHECK  = 8'h30;

    // Control word fields.
    localparam int C_EN     = 0;
    localparam int C_MASTER = 1;
    localparam int C_ASCII  = 2;
    localparam int C_CTS    = 3;
    localparam int C_PAR    = 4;
    localparam int C_DATA8  = 6;
    localparam int C_STOP2  = 7;
    localparam int C_FLOAT  = 8;
    localparam int C_LINE   = 9;
    localparam int CTRL_W   = 11;

    // Status word fields; error and end-of-message bits are write-one-to-clear.
    localparam int S_TXFULL  = 0;
    localparam int S_TXBUSY  = 1;
    localparam int S_RXVALID = 2;
    localparam int S_PERR    = 3;
    localparam int S_FERR    = 4;
    localparam int S_OVR     = 5;
    localparam int S_EOM     = 6;
    localparam int S_RTS     = 7;
    localparam int S_CTS     = 8;
    localparam int S_ANSWER  = 9;

    localparam int MAP_FLOAT = 16;
    localparam int CHK_CLEAR = 8;

    localparam logic [CTRL_W-1:0] CTRL_RST   = 11'h000;
    localparam logic [15:0]       BAUD_RST   = 16'h28B0;
    localparam logic [15:0]       DELAY_RST  = 16'h0000;
    localparam logic [14:0]       FSTART_RST = 15'h0000;
    localparam logic [11:0]       FBASE_RST  = 12'h000;
    localparam logic [11:0]       FBASE_MAX  = 12'hF9E;

    localparam logic [7:0]  FC_RD_HOLD  = 8'h03;
    localparam logic [7:0]  FC_WR_ONE   = 8'h06;
    localparam logic [7:0]  FC_WR_MULTI = 8'h10;
    localparam logic [15:0] CRC_POLY    = 16'hA001;
    localparam logic [15:0] CRC_INIT    = 16'hFFFF;
    localparam logic [7:0]  ASCII_LF    = 8'h0A;
    localparam logic [6:0]  EOM_HALF_PER_CHAR = 7'h07;

    typedef enum logic [1:0] {
        PAR_NONE = 2'b00,
        PAR_ODD  = 2'b01,
        PAR_EVEN = 2'b10
    } msplc_par_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_LEAD = 2'b01,
        TX_DATA = 2'b10,
        TX_TAIL = 2'b11
    } msplc_tx_t;

endpackage

// [msplc_tick.sv]
// Purpose: Programmable divider giving a one-cycle enable every div_i clocks.
// Assumes: Same clock as its user; restart_i realigns the phase.
// Notes:   A divisor of 0 or 1 gives an enable on every cycle.
module msplc_tick
    import msplc_pkg::*;
#(
    parameter int W = 16
)(
    input  wire logic         clk_i,     // System clock.
    input  wire logic         rst_i,     // Asynchronous reset, active high.
    input  wire logic         en_i,      // Run the divider.
    input  wire logic         restart_i, // Restart the period from zero.
    input  wire logic [W-1:0] div_i,     // Clocks per enable pulse.
    output logic              tick_o     // One-cycle enable pulse.
);

    if (W < 2 || W > 24)
    begin : g_bad_width
        $error("msplc_tick: width out of range");
    end

    logic [W-1:0] cnt_q;
    wire  logic   at_end;

    assign at_end = ({1'b0, cnt_q} + {{W{1'b0}}, 1'b1}) >= {1'b0, div_i};
    assign tick_o = en_i && !restart_i && at_end;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_q <= '0; // RULE_18
        else if (restart_i || !en_i || at_end)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 1'b1;
    end

    chk_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_18
        (tick_o && div_i > 1 && $stable(div_i)) |=> !tick_o)
        else $error("tick pulses closer than the divisor");

endmodule

// [msplc_port.sv]
// Purpose: Serial gateway port: character engine, modem handshake, message end, float remap.
// Assumes: Registers on a plain port with read data one cycle after the read strobe.
// Notes:   Message check bytes are built by software through the check accumulator.
// How it works
// [RULE_01] Port disabled: no transmission, received traffic ignored.
// [RULE_02] Master sends freely; slave sends only after a received request.
// [RULE_03] Float remap applies only to function codes 3, 6 and 16.
// [RULE_04] Register at or above float threshold is float, only when enabled.
// [RULE_05] Float requests address the database from float base upward.
// [RULE_06] Port selects binary or character-coded framing.
// [RULE_07] Binary framing uses CRC-16, character-coded uses LRC.
// [RULE_08] Bit rate set by a per-port divider.
// [RULE_09] Parity none, odd or even generated and checked.
// [RULE_10] Seven or eight data bits per character.
// [RULE_11] One or two stop bits per character.
// [RULE_12] All line devices share parity, data and stop settings.
// [RULE_13] After raising RTS, wait configured milliseconds before first bit.
// [RULE_14] After last byte, hold RTS configured milliseconds, then drop it.
// [RULE_15] With CTS in use, characters start only while CTS high.
// [RULE_16] With CTS unused, CTS input is ignored.
// [RULE_17] Binary framing: message ends after 3.5 characters silence plus extra delay.
// [RULE_18] Millisecond tick from programmable divider; counters cleared on reset.
module msplc_port
    import msplc_pkg::*;
#(
    parameter int MS_DIV_DEFAULT = MS_CYCLES
)(
    input  wire logic        clk_i,      // System clock, 100 MHz.
    input  wire logic        rst_i,      // Asynchronous reset, active high.
    input  wire logic [7:0]  addr_i,     // Register byte address.
    input  wire logic [31:0] wdata_i,    // Register write data.
    input  wire logic        we_i,       // Write strobe.
    input  wire logic        re_i,       // Read strobe.
    output logic      [31:0] rdata_o,    // Read data, cycle after re_i.
    input  wire logic        rxd_i,      // Serial receive pin.
    input  wire logic        cts_i,      // Clear-to-send pin.
    output logic             txd_o,      // Serial transmit pin.
    output logic             rts_o,      // Request-to-send pin.
    output logic      [1:0]  line_sel_o  // Line electrical select to transceiver.
);

    if (MS_DIV_DEFAULT < 1 || MS_DIV_DEFAULT > 20'hFFFFF)
    begin : g_bad_ms
        $error("msplc_port: millisecond divisor does not fit");
    end

    function automatic logic par_bit(input logic [7:0] d, input logic d8, input logic odd);
        return (d8 ? ^d : ^d[6:0]) ^ odd;
    endfunction

    function automatic logic [3:0] frame_len(input logic d8, input msplc_par_t p, input logic st2);
        return 4'h1 + (d8 ? 4'h8 : 4'h7) + ((p != PAR_NONE) ? 4'h1 : 4'h0) + (st2 ? 4'h2 : 4'h1);
    endfunction

    function automatic logic [11:0] mk_frame(input logic [7:0] d, input logic d8, input msplc_par_t p);
        logic [11:0] f;
        logic        pb;
        pb   = par_bit(d, d8, p == PAR_ODD);
        f    = 12'hFFF;
        f[0] = 1'b0;
        if (d8)
            f[8:1] = d;
        else
            f[7:1] = d[6:0];
        if (p != PAR_NONE)
        begin
            if (d8)
                f[9] = pb;
            else
                f[8] = pb;
        end
        return f;
    endfunction

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        return r;
    endfunction

    logic [CTRL_W-1:0] ctrl_q;
    logic [15:0]       baud_q, rtson_q, rtsoff_q, eomdly_q, tms_q, rms_q, chk_q;
    logic [19:0]       msdiv_q;
    logic [14:0]       fstart_q;
    logic [11:0]       fbase_q;
    logic [23:0]       map_q;
    logic [7:0]        txbuf_q, rxdata_q;
    logic              txfull_q, rxvalid_q, perr_q, ferr_q, ovr_q, eom_q, answer_q, msg_q, rts_q;
    logic [11:0]       sh_q;
    logic [3:0]        bits_q;
    logic              rx1_q, rx2_q, rx3_q, cts1_q, cts2_q, rx_busy_q;
    logic [4:0]        rx_half_q;
    logic [10:0]       rxsh_q;
    logic [6:0]        sil_q;
    logic [31:0]       rdata_q;
    msplc_tx_t         st_q, st_d;

    wire logic       c_en     = ctrl_q[C_EN];
    wire logic       c_master = ctrl_q[C_MASTER];
    wire logic       c_ascii  = ctrl_q[C_ASCII];
    wire logic       c_cts    = ctrl_q[C_CTS];
    wire logic       c_d8     = ctrl_q[C_DATA8];
    wire logic       c_st2    = ctrl_q[C_STOP2];
    wire logic       c_float  = ctrl_q[C_FLOAT];
    wire msplc_par_t c_par    = msplc_par_t'(ctrl_q[C_PAR+1:C_PAR]);

    wire logic wr_ctrl   = we_i && addr_i == A_CTRL;
    wire logic wr_tx     = we_i && addr_i == A_TXDATA;
    wire logic wr_status = we_i && addr_i == A_STATUS;
    wire logic wr_chk    = we_i && addr_i == A_CHECK;
    wire logic rd_rx     = re_i && addr_i == A_RXDATA;

    // Character geometry shared by transmitter, receiver and gap detector.
    wire logic [3:0] flen = frame_len(c_d8, c_par, c_st2); // RULE_10 RULE_11
    wire logic [3:0] rlen = flen - {3'h0, c_st2};
    wire logic [6:0] thr  = {3'h0, flen} * EOM_HALF_PER_CHAR; // RULE_17

    // Transmitter.
    logic tx_bit_tick, tx_ms_tick, rx_half_tick, rx_ms_tick;
    wire logic cts_ok    = !c_cts || cts2_q; // RULE_15 RULE_16
    wire logic load      = st_q == TX_DATA && bits_q == 4'h0 && txfull_q && cts_ok; // RULE_15
    wire logic lead_done = tms_q >= rtson_q; // RULE_13
    wire logic st_chg    = st_q != st_d;

    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            TX_IDLE: if (txfull_q && (c_master || answer_q)) st_d = TX_LEAD; // RULE_02
            TX_LEAD: if (lead_done) st_d = TX_DATA; // RULE_13
            TX_DATA: if (bits_q == 4'h0 && !txfull_q) st_d = TX_TAIL;
            TX_TAIL: if (txfull_q) st_d = TX_DATA;
                     else if (tms_q >= rtsoff_q) st_d = TX_IDLE; // RULE_14
        endcase
        if (!c_en)
            st_d = TX_IDLE; // RULE_01
    end

    msplc_tick #(.W(16)) u_tx_bit (.clk_i(clk_i), .rst_i(rst_i), .en_i(st_q == TX_DATA), // RULE_08
        .restart_i(load), .div_i(baud_q), .tick_o(tx_bit_tick));
    msplc_tick #(.W(20)) u_tx_ms (.clk_i(clk_i), .rst_i(rst_i), .en_i(c_en), // RULE_18
        .restart_i(st_chg), .div_i(msdiv_q), .tick_o(tx_ms_tick));

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q   <= TX_IDLE;
            rts_q  <= 1'b0;
            tms_q  <= '0;
            sh_q   <= 12'hFFF;
            bits_q <= '0;
        end
        else
        begin
            st_q  <= st_d;
            rts_q <= st_d != TX_IDLE; // RULE_13 RULE_14
            tms_q <= st_chg ? 16'h0000 : tms_q + {15'h0, tx_ms_tick && tms_q != 16'hFFFF};
            if (!c_en)
            begin
                sh_q   <= 12'hFFF;
                bits_q <= '0;
            end
            else if (load)
            begin
                sh_q   <= mk_frame(txbuf_q, c_d8, c_par); // RULE_06 RULE_09
                bits_q <= flen;
            end
            else if (tx_bit_tick && bits_q != 4'h0)
            begin
                sh_q   <= {1'b1, sh_q[11:1]};
                bits_q <= bits_q - 4'h1;
            end
        end
    end

    // Receiver; the pins pass two flip-flops, the third only delays for the edge detector.
    wire logic        rx_start = c_en && !rx_busy_q && rx3_q && !rx2_q; // RULE_01
    wire logic        rx_samp  = rx_busy_q && rx_half_tick && !rx_half_q[0];
    wire logic [3:0]  rx_idx   = rx_half_q[4:1];
    wire logic        rx_abort = rx_samp && rx_idx == 4'h0 && rx2_q;
    wire logic        rx_fin   = rx_samp && rx_idx == rlen - 4'h1;
    wire logic [10:0] rx_full  = {rx2_q, rxsh_q[10:1]};
    wire logic [10:0] rx_al    = rx_full >> (4'hB - rlen);
    wire logic [7:0]  rx_byte  = c_d8 ? rx_al[8:1] : {1'b0, rx_al[7:1]}; // RULE_10
    wire logic        rx_pbit  = c_d8 ? rx_al[9] : rx_al[8];
    wire logic        rx_perr  = c_par != PAR_NONE && rx_pbit != par_bit(rx_byte, c_d8, c_par == PAR_ODD); // RULE_09
    wire logic        sil_done = sil_q >= thr;
    wire logic        eom_p    = c_en && (c_ascii ? (rx_fin && rx_byte == ASCII_LF) // RULE_06
                               : (msg_q && sil_done && rms_q >= eomdly_q && !rx_busy_q)); // RULE_17

    msplc_tick #(.W(16)) u_rx_half (.clk_i(clk_i), .rst_i(rst_i), .en_i(c_en), // RULE_08
        .restart_i(rx_start), .div_i({1'b0, baud_q[15:1]}), .tick_o(rx_half_tick));
    msplc_tick #(.W(20)) u_rx_ms (.clk_i(clk_i), .rst_i(rst_i), .en_i(c_en), // RULE_18
        .restart_i(!sil_done), .div_i(msdiv_q), .tick_o(rx_ms_tick));

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            {rx1_q, rx2_q, rx3_q, cts1_q, cts2_q} <= 5'h1F;
            rx_busy_q <= 1'b0;
            rx_half_q <= '0;
            rxsh_q    <= '0;
            sil_q     <= '0;
            rms_q     <= '0;
            msg_q     <= 1'b0;
        end
        else
        begin
            rx1_q     <= rxd_i;
            rx2_q     <= rx1_q;
            rx3_q     <= rx2_q;
            cts1_q    <= cts_i;
            cts2_q    <= cts1_q;
            rx_busy_q <= c_en && (rx_start || (rx_busy_q && !rx_abort && !rx_fin));
            rx_half_q <= rx_start ? 5'h00 : rx_half_q + {4'h0, rx_busy_q && rx_half_tick};
            if (rx_samp)
                rxsh_q <= rx_full;
            if (rx_start || rx_fin)
                sil_q <= '0;
            else if (msg_q && !rx_busy_q && rx_half_tick && !sil_done)
                sil_q <= sil_q + 7'h01; // RULE_17
            rms_q <= !sil_done ? 16'h0000 : rms_q + {15'h0, rx_ms_tick && rms_q != 16'hFFFF};
            msg_q <= c_en && !eom_p && (rx_fin || msg_q);
        end
    end

    // Request remapping for floating-point register ranges.
    wire logic [7:0]  map_fc    = map_q[23:16];
    wire logic [15:0] map_reg   = map_q[15:0];
    wire logic        fc_ok     = map_fc == FC_RD_HOLD || map_fc == FC_WR_ONE || map_fc == FC_WR_MULTI; // RULE_03
    wire logic        map_float = c_float && fc_ok && map_reg >= {1'b0, fstart_q}; // RULE_04
    wire logic [15:0] map_addr  = map_float ? ({4'h0, fbase_q} + (map_reg - {1'b0, fstart_q})) : map_reg; // RULE_05

    wire logic [15:0] chk_rd = c_ascii ? {8'h00, 8'h00 - chk_q[7:0]} : chk_q; // RULE_07
    wire logic [31:0] status = {22'h0, answer_q, cts2_q, rts_q, eom_q, ovr_q, ferr_q, perr_q,
                                rxvalid_q, st_q != TX_IDLE, txfull_q};
    wire logic [31:0] rd_mux =
        addr_i == A_CTRL   ? {21'h0, ctrl_q} :
        addr_i == A_BAUD   ? {16'h0, baud_q} :
        addr_i == A_MSDIV  ? {12'h0, msdiv_q} :
        addr_i == A_RTSON  ? {16'h0, rtson_q} :
        addr_i == A_RTSOFF ? {16'h0, rtsoff_q} :
        addr_i == A_EOMDLY ? {16'h0, eomdly_q} :
        addr_i == A_FSTART ? {17'h0, fstart_q} :
        addr_i == A_FBASE  ? {20'h0, fbase_q} :
        addr_i == A_RXDATA ? {24'h0, rxdata_q} :
        addr_i == A_STATUS ? status :
        addr_i == A_MAP    ? {15'h0, map_float, map_addr} :
        addr_i == A_CHECK  ? {16'h0, chk_rd} : 32'h0000_0000;

    // Error and message flags: a hardware set in the clearing cycle wins.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_q   <= CTRL_RST;
            baud_q   <= BAUD_RST;
            msdiv_q  <= 20'(MS_DIV_DEFAULT);
            {rtson_q, rtsoff_q, eomdly_q} <= {3{DELAY_RST}};
            fstart_q <= FSTART_RST;
            fbase_q  <= FBASE_RST;
            map_q    <= '0;
            chk_q    <= CRC_INIT;
            txbuf_q  <= '0;
            rxdata_q <= '0;
            {txfull_q, rxvalid_q, perr_q, ferr_q, ovr_q, eom_q, answer_q} <= '0;
            rdata_q  <= '0;
        end
        else
        begin
            rdata_q <= re_i ? rd_mux : 32'h0000_0000;
            if (wr_ctrl)
                ctrl_q <= wdata_i[CTRL_W-1:0];
            if (we_i && addr_i == A_BAUD)
                baud_q <= wdata_i[15:0];
            if (we_i && addr_i == A_MSDIV)
                msdiv_q <= wdata_i[19:0];
            if (we_i && addr_i == A_RTSON)
                rtson_q <= wdata_i[15:0];
            if (we_i && addr_i == A_RTSOFF)
                rtsoff_q <= wdata_i[15:0];
            if (we_i && addr_i == A_EOMDLY)
                eomdly_q <= wdata_i[15:0];
            if (we_i && addr_i == A_FSTART)
                fstart_q <= wdata_i[14:0];
            if (we_i && addr_i == A_FBASE)
                fbase_q <= (wdata_i[11:0] > FBASE_MAX) ? FBASE_MAX : wdata_i[11:0];
            if (we_i && addr_i == A_MAP)
                map_q <= wdata_i[23:0];
            if (wr_chk && wdata_i[CHK_CLEAR])
                chk_q <= c_ascii ? 16'h0000 : CRC_INIT;
            else if (wr_chk)
                chk_q <= c_ascii ? chk_q + {8'h00, wdata_i[7:0]} : crc_byte(chk_q, wdata_i[7:0]); // RULE_07
            if (wr_tx && c_en && !txfull_q)
                txbuf_q <= wdata_i[7:0];
            txfull_q <= c_en && ((wr_tx && !txfull_q) || (txfull_q && !load)); // RULE_01
            if (rx_fin)
                rxdata_q <= rx_byte;
            rxvalid_q <= c_en && (rx_fin || (rxvalid_q && !rd_rx));
            perr_q    <= (rx_fin && rx_perr) || (perr_q && !(wr_status && wdata_i[S_PERR]));
            ferr_q    <= (rx_fin && !rx2_q) || (ferr_q && !(wr_status && wdata_i[S_FERR]));
            ovr_q     <= (rx_fin && rxvalid_q && !rd_rx) || (ovr_q && !(wr_status && wdata_i[S_OVR]));
            eom_q     <= eom_p || (eom_q && !(wr_status && wdata_i[S_EOM]));
            answer_q  <= c_en && ((eom_p && !c_master) || (answer_q && !(st_q == TX_TAIL && st_d == TX_IDLE))); // RULE_02
        end
    end

    assign rdata_o    = rdata_q;
    assign txd_o      = sh_q[0];
    assign rts_o      = rts_q;
    assign line_sel_o = ctrl_q[C_LINE+1:C_LINE];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_enter_lead;
        st_q == TX_IDLE ##1 st_q == TX_LEAD;
    endsequence
    sequence s_enter_idle;
        st_q == TX_TAIL ##1 st_q == TX_IDLE;
    endsequence

    chk_disable_quiet: assert property (!c_en |=> st_q == TX_IDLE && !rts_o && txd_o && !rxvalid_q) // RULE_01
        else $error("port active while disabled");
    chk_slave_answers: assert property (s_enter_lead |-> $past(c_master) || $past(answer_q)) // RULE_02
        else $error("slave transmitted without a request");
    chk_float_codes: assert property (map_float |-> c_float && fc_ok) // RULE_03
        else $error("float remap on wrong function code");
    chk_float_threshold: assert property ((re_i && addr_i == A_MAP && map_reg < {1'b0, fstart_q}) // RULE_04
        |=> !rdata_o[MAP_FLOAT] && rdata_o[15:0] == $past(map_reg))
        else $error("register below threshold was remapped");
    chk_float_base: assert property ((re_i && addr_i == A_MAP && map_float && map_reg == {1'b0, fstart_q}) // RULE_05
        |=> rdata_o[15:0] == {4'h0, $past(fbase_q)})
        else $error("threshold register not mapped to base");
    chk_rts_lead: assert property ((st_q == TX_LEAD && !lead_done && c_en) |=> rts_o && txd_o) // RULE_13
        else $error("data sent before turn-on delay");
    chk_rts_hold: assert property (s_enter_idle |-> !rts_o && (!$past(c_en) || $past(tms_q) >= $past(rtsoff_q))) // RULE_14
        else $error("RTS dropped before turn-off delay");
    chk_cts_gate: assert property ((st_q == TX_DATA && bits_q == 4'h0 && c_cts && !cts2_q) |=> bits_q == 4'h0) // RULE_15
        else $error("character started with CTS low");
    chk_cts_ignored: assert property ((st_q == TX_DATA && bits_q == 4'h0 && txfull_q && !c_cts && c_en) // RULE_16
        |=> bits_q == $past(flen) && !txd_o)
        else $error("character held back while CTS unused");
    chk_eom_gap: assert property ((eom_p && !c_ascii) |-> sil_q >= thr && rms_q >= eomdly_q) // RULE_17
        else $error("message end before silent gap");

endmodule

// [msplc_peer.sv]
// Purpose: Line partner: modem that grants CTS with RTS, and a device that sends and captures frames.
// Assumes: 8 data bits, even parity, one stop bit, BAUD clocks per bit.
// Notes:   The receive line idles high, as a pulled-up line would.
module msplc_peer #(
    parameter int BAUD = 20
)(
    input  wire logic clk_i, // System clock.
    input  wire logic txd_i, // Line from the port.
    input  wire logic rts_i, // Request-to-send from the port.
    output logic      rxd_o, // Line into the port.
    output logic      cts_o  // Clear-to-send to the port.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q;
    int         got_n = 0;
    initial rxd_o = 1'b1;
    assign cts_o = rts_i;
    // Sample in mid-bit so small start jitter does not matter.
    always
    begin : listen
        @(negedge txd_i);
        repeat (BAUD + BAUD / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++)
        begin
            got_q[i] = txd_i;
            repeat (BAUD) @(posedge clk_i);
        end
        repeat (2 * BAUD) @(posedge clk_i);
        got_n++;
    end
    task automatic send(input logic [7:0] b);
        logic [10:0] f;
        f = {1'b1, ^b, b, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            rxd_o <= f[i];
            repeat (BAUD) @(posedge clk_i);
        end
    endtask
endmodule

// [tb_top.sv]
// Purpose: Self-checking bench for the serial port line control block.
// Assumes: Short bit and millisecond divisors so the run stays brief.
// Notes:   Random values come from a fixed-seed shift register.
module tb_top;
    import msplc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, re_i = 1'b0, rxd, cts, txd_o, rts_o;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, rv, seed = 32'hA3AC7142;
    logic [1:0]  line_sel_o;
    int err_total = 0, n_checks = 0, t;
    msplc_port #(.MS_DIV_DEFAULT(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .rxd_i(rxd), .cts_i(cts), .txd_o(txd_o), .rts_o(rts_o),
        .line_sel_o(line_sel_o));
    msplc_peer #(.BAUD(20)) peer (.clk_i(clk_i), .txd_i(txd_o), .rts_i(rts_o), .rxd_o(rxd), .cts_o(cts));
    initial forever #5 clk_i = ~clk_i;
    function automatic logic [31:0] rnd(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
        c = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        return c;
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        we_i    <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        re_i   <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 rv = rdata_o;
    endtask
    // Bounded wait for the partner to capture its n-th byte.
    task automatic wait_rx(input int n);
        for (t = 0; t < 20000 && peer.got_n < n; t++) @(posedge clk_i);
        if (t == 20000) begin err_total++; stop_test(); end
    endtask
    initial
    begin
        logic [15:0] r, c;
        logic [7:0]  fc, b;
        logic        f;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(A_BAUD); chk("baud", rv, 32'h28B0);
        rd(8'h40); chk("unmapped", rv, 32'h0);
        wr(A_CTRL, 32'h100); wr(A_FSTART, 32'h1B58); wr(A_FBASE, 32'hBB8);
        for (int k = 0; k < 12; k++)
        begin
            seed = rnd(seed);
            fc = k[1] ? (k[0] ? 8'h04 : 8'h10) : (k[0] ? 8'h06 : 8'h03);
            r = (k < 4) ? 16'h1B57 + 16'(k % 2) : seed[15:0];
            if (k == 11) wr(A_CTRL, 32'h600);
            f = (k < 11) && (fc != 8'h04) && (r >= 16'h1B58);
            wr(A_MAP, {8'h00, fc, r}); rd(A_MAP);
            chk("map", rv, {15'h0, f, f ? r - 16'h1B58 + 16'hBB8 : r});
            if (k == 11) chk("line", {30'h0, line_sel_o}, 32'h3);
        end
        wr(A_CHECK, 32'h100); c = 16'hFFFF;
        for (int k = 0; k < 4; k++) begin seed = rnd(seed); c = crc(c, seed[7:0]); wr(A_CHECK, {24'h0, seed[7:0]}); end
        rd(A_CHECK); chk("crc", rv, {16'h0, c});
        wr(A_TXDATA, 32'h55); rd(A_STATUS); chk("off full", rv[0], 32'h0);
        wr(A_BAUD, 32'd20); wr(A_MSDIV, 32'd10); wr(A_RTSON, 32'd2); wr(A_RTSOFF, 32'd3);
        wr(A_CTRL, 32'h61); seed = rnd(seed); b = seed[7:0]; wr(A_TXDATA, {24'h0, b});
        repeat (100) @(posedge clk_i);
        chk("slave rts", rts_o, 32'h0);
        wr(A_CTRL, 32'h63);
        for (t = 0; t < 100 && rts_o !== 1'b1; t++) @(posedge clk_i);
        chk("rts up", rts_o, 32'h1);
        for (t = 0; t < 100 && txd_o !== 1'b0; t++) @(posedge clk_i);
        chk("lead", (t >= 19 && t <= 24), 32'h1);
        wait_rx(1); chk("tx byte", peer.got_q, b);
        for (t = 0; t < 200 && rts_o !== 1'b0; t++) @(posedge clk_i);
        // The partner reports the byte half a bit after the stop bit ends, so 3 ms less 10 clocks remain.
        chk("tail", (t >= 18 && t <= 27), 32'h1);
        seed = rnd(seed); b = seed[7:0]; peer.send(b);
        repeat (40) @(posedge clk_i);
        rd(A_RXDATA); chk("rx byte", rv, {24'h0, b});
        stop_test();
    end
endmodule
